//--- nvs_pkg.sv
// Contract
// - Data moves both ways on one shared 8-bit bus for reads and writes.
// - Chip select low selects the memory; it answers only while selected.
// - The host may start a store by pulling store_busy_n low from outside.
// - The host requests such a store through store_req_in; there is no restore request.
package nvs_pkg;
	localparam int ADDR_W      = 13;
	localparam int DATA_W      = 8;
	localparam int CLK_PERIOD_NS = 4;
	// Access time of the slowest grade; a shorter grade works with this count
	localparam int ACCESS_NS   = 55;
	localparam int ACCESS_CYC  = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STROBE_NS   = 8;
	localparam int STROBE_CYC  = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W       = 8;

	typedef struct packed {
		logic              write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} nvs_req_t;

	typedef enum logic [4:0] {
		NVS_IDLE   = 5'h01,
		NVS_ACCESS = 5'h02,
		NVS_REL    = 5'h04,
		NVS_STORE  = 5'h08,
		NVS_WAIT   = 5'h10
	} nvs_state_t;
endpackage

//--- nvs_host.sv
`timescale 1ns/100ps
module nvs_host #(
	parameter int ACC_CYC = nvs_pkg::ACCESS_CYC,
	parameter int STB_CYC = nvs_pkg::STROBE_CYC
) (
	input  wire logic                      core_clk_in,
	input  wire logic                      rst_in,
	input  wire logic                      req_valid_in,
	input  wire nvs_pkg::nvs_req_t         req_in,
	output logic                           req_ready_out,
	input  wire logic                      store_req_in,
	output logic                           store_ready_out,
	output logic                           rd_valid_out,
	output logic [nvs_pkg::DATA_W-1:0]     rd_data_out,
	output logic                           store_done_out,
	output logic                           busy_out,
	output logic [nvs_pkg::ADDR_W-1:0]     mem_addr_out,
	output logic                           mem_cs_n_out,
	output logic                           mem_we_n_out,
	output logic                           mem_oe_n_out,
	input  wire logic [nvs_pkg::DATA_W-1:0] data_bus_in,
	output logic [nvs_pkg::DATA_W-1:0]     data_bus_out,
	output logic                           data_bus_oe_n_out,
	input  wire logic                      store_busy_n_in,
	output logic                           store_busy_n_out,
	output logic                           store_busy_n_oe_n_out
);
	nvs_pkg::nvs_state_t          state_r, state_nxt;
	logic [nvs_pkg::CNT_W-1:0]    cnt_r, cnt_nxt;
	logic                         wr_r;
	logic [nvs_pkg::ADDR_W-1:0]   addr_r;
	logic [nvs_pkg::DATA_W-1:0]   wdata_r;
	logic [nvs_pkg::DATA_W-1:0]   rdata_r;
	logic                         rd_valid_r;
	logic                         done_r;

	function automatic logic [nvs_pkg::CNT_W-1:0] cyc(input int n);
		cyc = nvs_pkg::CNT_W'(n);
	endfunction

	wire logic in_idle   = (state_r == nvs_pkg::NVS_IDLE);
	wire logic in_access = (state_r == nvs_pkg::NVS_ACCESS);
	wire logic in_store  = (state_r == nvs_pkg::NVS_STORE);
	wire logic cnt_zero  = (cnt_r == '0);
	// Line high means idle; the pull-up covers the undriven case
	wire logic mem_idle  = store_busy_n_in;
	wire logic take_acc  = in_idle & mem_idle & req_valid_in & ~store_req_in;
	wire logic take_sto  = in_idle & mem_idle & store_req_in;

	assign req_ready_out   = in_idle & mem_idle & ~store_req_in;
	assign store_ready_out = in_idle & mem_idle;
	assign busy_out        = ~in_idle | ~mem_idle;
	assign rd_valid_out    = rd_valid_r;
	assign rd_data_out     = rdata_r;
	assign store_done_out  = done_r;
	assign mem_addr_out    = addr_r;
	assign mem_cs_n_out    = ~in_access;
	assign mem_we_n_out    = ~(in_access & wr_r);
	assign mem_oe_n_out    = ~(in_access & ~wr_r);
	assign data_bus_out    = wdata_r;
	// Host drives the bus only in a write, so the two ends never fight
	assign data_bus_oe_n_out     = ~(in_access & wr_r);
	assign store_busy_n_out      = 1'b0;
	assign store_busy_n_oe_n_out = ~in_store;

	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_zero ? cnt_r : cnt_r - 1'b1;
		case (state_r)
			nvs_pkg::NVS_IDLE: begin
				if (take_sto) begin
					state_nxt = nvs_pkg::NVS_STORE;
					cnt_nxt   = cyc(STB_CYC - 1);
				end else if (take_acc) begin
					state_nxt = nvs_pkg::NVS_ACCESS;
					cnt_nxt   = cyc(ACC_CYC - 1);
				end
			end
			nvs_pkg::NVS_ACCESS: begin
				if (cnt_zero)
					state_nxt = nvs_pkg::NVS_REL;
			end
			nvs_pkg::NVS_REL: state_nxt = nvs_pkg::NVS_IDLE;
			nvs_pkg::NVS_STORE: begin
				if (cnt_zero)
					state_nxt = nvs_pkg::NVS_WAIT;
			end
			// Wait for the memory to let the line rise at store end
			nvs_pkg::NVS_WAIT: begin
				if (store_busy_n_in)
					state_nxt = nvs_pkg::NVS_IDLE;
			end
			default: state_nxt = nvs_pkg::NVS_IDLE;
		endcase
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			state_r <= nvs_pkg::NVS_IDLE;
			cnt_r   <= '0;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			wr_r    <= 1'b0;
			addr_r  <= '0;
			wdata_r <= '0;
		end else if (take_acc) begin
			wr_r    <= req_in.write;
			addr_r  <= req_in.addr;
			wdata_r <= req_in.wdata;
		end
	end

	// Sample read data at the end of the access, before output enable rises
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			rdata_r    <= '0;
			rd_valid_r <= 1'b0;
			done_r     <= 1'b0;
		end else begin
			rd_valid_r <= in_access & cnt_zero & ~wr_r;
			done_r     <= (state_r == nvs_pkg::NVS_WAIT) & store_busy_n_in;
			if (in_access & cnt_zero & ~wr_r)
				rdata_r <= data_bus_in;
		end
	end

	property p_oe_read_only;
		@(posedge core_clk_in) disable iff (rst_in)
		~mem_oe_n_out |-> (~mem_cs_n_out & mem_we_n_out & data_bus_oe_n_out);
	endproperty
	a_oe_read_only: assert property (p_oe_read_only)
		else $error("Output enable outside a read");

	property p_we_sel;
		@(posedge core_clk_in) disable iff (rst_in)
		~mem_we_n_out |-> (~mem_cs_n_out & ~data_bus_oe_n_out & mem_oe_n_out);
	endproperty
	a_we_sel: assert property (p_we_sel)
		else $error("Write strobe without select and data");

	sequence s_take;
		take_acc;
	endsequence
	sequence s_sel_hold;
		~mem_cs_n_out [*3];
	endsequence
	property p_access_len;
		@(posedge core_clk_in) disable iff (rst_in)
		s_take |=> s_sel_hold;
	endproperty
	a_access_len: assert property (p_access_len)
		else $error("Select dropped early");

	property p_release;
		@(posedge core_clk_in) disable iff (rst_in)
		(in_access & cnt_zero) |=>
			(mem_cs_n_out & mem_oe_n_out & data_bus_oe_n_out);
	endproperty
	a_release: assert property (p_release)
		else $error("Bus not released after access");

	property p_addr_stable;
		@(posedge core_clk_in) disable iff (rst_in)
		(~mem_cs_n_out & $past(~mem_cs_n_out)) |-> $stable(mem_addr_out);
	endproperty
	a_addr_stable: assert property (p_addr_stable)
		else $error("Address moved during select");

	property p_store_pull;
		@(posedge core_clk_in) disable iff (rst_in)
		take_sto |=> ~store_busy_n_oe_n_out ##1 ~store_busy_n_oe_n_out;
	endproperty
	a_store_pull: assert property (p_store_pull)
		else $error("Store pull too short");

	property p_no_access_busy;
		@(posedge core_clk_in) disable iff (rst_in)
		(in_idle & ~store_busy_n_in) |=> mem_cs_n_out;
	endproperty
	a_no_access_busy: assert property (p_no_access_busy)
		else $error("Access started while memory busy");

	property p_done;
		@(posedge core_clk_in) disable iff (rst_in)
		store_done_out |-> ($past(store_busy_n_in) & in_idle);
	endproperty
	a_done: assert property (p_done)
		else $error("Store done before line released");

	property p_write_data;
		@(posedge core_clk_in) disable iff (rst_in)
		(~mem_we_n_out & $past(~mem_we_n_out)) |-> $stable(data_bus_out);
	endproperty
	a_write_data: assert property (p_write_data)
		else $error("Write data moved under strobe");

	property p_read_sample;
		@(posedge core_clk_in) disable iff (rst_in)
		rd_valid_out |-> ($past(~mem_oe_n_out) & mem_oe_n_out);
	endproperty
	a_read_sample: assert property (p_read_sample)
		else $error("Read data not taken under output enable");

	sequence s_line_low;
		(state_r == nvs_pkg::NVS_WAIT) & ~store_busy_n_in;
	endsequence
	property p_wait_hold;
		@(posedge core_clk_in) disable iff (rst_in)
		s_line_low |=> (mem_cs_n_out & ~store_done_out & ~req_ready_out);
	endproperty
	a_wait_hold: assert property (p_wait_hold)
		else $error("Store end taken while line low");

	property p_idle_quiet;
		@(posedge core_clk_in) disable iff (rst_in)
		in_idle |-> (mem_cs_n_out & mem_we_n_out & mem_oe_n_out
			& data_bus_oe_n_out & store_busy_n_oe_n_out);
	endproperty
	a_idle_quiet: assert property (p_idle_quiet)
		else $error("Pin driven while idle");

	// No access may overlap the pull; the memory model would still answer a read then
	property p_store_quiet;
		@(posedge core_clk_in) disable iff (rst_in)
		in_store |-> (mem_cs_n_out & ~store_busy_n_out & ~store_busy_n_oe_n_out);
	endproperty
	a_store_quiet: assert property (p_store_quiet)
		else $error("Store pull without quiet bus");
endmodule

//--- nvs_mem_model.sv
`timescale 1ns/100ps
module nvs_mem_model #(
	parameter int STORE_CYC = 20
) (
	input  wire logic        clk_in,
	input  wire logic [12:0] addr_in,
	input  wire logic        cs_n_in,
	input  wire logic        we_n_in,
	input  wire logic        oe_n_in,
	input  wire logic [7:0]  data_bus_in,
	input  wire logic        store_busy_n_in,
	input  wire logic        power_fail_in,
	output logic [7:0]       data_bus_out,
	output logic             drive_out,
	output logic             store_busy_n_oe_n_out
);
	logic [7:0] mem [0:8191];
	// Known fill so a missing restore shows up as unknown data
	logic [7:0] nv  [0:8191] = '{default: 8'h5a};
	int         cnt = 0;
	logic       armed = 1'b0;
	initial mem = nv;
	assign data_bus_out = mem[addr_in];
	assign drive_out = !cs_n_in && !oe_n_in && we_n_in;
	assign store_busy_n_oe_n_out = (cnt == 0);
	// Armed only after the line was seen high, so our own pull never restarts
	always @(posedge clk_in) begin
		armed <= store_busy_n_in;
		if (!cs_n_in && !we_n_in && cnt == 0)
			mem[addr_in] <= data_bus_in;
		if (cnt != 0)
			cnt <= cnt - 1;
		else if ((!store_busy_n_in && armed) || power_fail_in) begin
			cnt <= STORE_CYC;
			nv <= mem;
		end
	end
endmodule

//--- nvs_tb.sv
`timescale 1ns/100ps
module testbench;
	logic              clk = 0, rst = 1, valid = 0, st_req = 0, pf = 0;
	nvs_pkg::nvs_req_t req = '0;
	logic              ready, st_ready, rd_valid, done, cs_n, we_n, oe_n;
	logic              d_oe_n, h_oe_n, dev_drv, dev_h_oe_n, store_busy_n, h_out, busy;
	logic [12:0]       addr;
	logic [7:0]        rd_data, d_out, dev_d, bus, pat = 8'h55;
	int                err_total = 0, num_checks = 0;
	initial forever #2 clk = ~clk;
	// Released bus toggles so a stale value never passes for data
	always @(posedge clk) pat <= ~pat;
	assign bus = !d_oe_n ? d_out : dev_drv ? dev_d : pat;
	assign store_busy_n = (h_oe_n || h_out) && dev_h_oe_n;
	nvs_host u_nvs_host (.core_clk_in(clk), .rst_in(rst),
		.req_valid_in(valid), .req_in(req), .req_ready_out(ready),
		.store_req_in(st_req), .store_ready_out(st_ready),
		.rd_valid_out(rd_valid), .rd_data_out(rd_data),
		.store_done_out(done), .busy_out(busy), .mem_addr_out(addr),
		.mem_cs_n_out(cs_n), .mem_we_n_out(we_n), .mem_oe_n_out(oe_n),
		.data_bus_in(bus), .data_bus_out(d_out),
		.data_bus_oe_n_out(d_oe_n), .store_busy_n_in(store_busy_n),
		.store_busy_n_out(h_out), .store_busy_n_oe_n_out(h_oe_n));
	nvs_mem_model u_nvs_mem_model (.clk_in(clk), .addr_in(addr),
		.cs_n_in(cs_n), .we_n_in(we_n), .oe_n_in(oe_n),
		.data_bus_in(bus), .store_busy_n_in(store_busy_n), .power_fail_in(pf),
		.data_bus_out(dev_d), .drive_out(dev_drv),
		.store_busy_n_oe_n_out(dev_h_oe_n));
	task finish_test;
		if (err_total == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task chk(string n, logic [7:0] e, logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			$display("wrong value %s exp %h got %h", n, e, g);
			err_total++;
		end
	endtask
	task automatic wait_hi(ref logic s, output int n);
		for (n = 0; n < 200; n++) begin
			@(negedge clk);
			if (s === 1'b1)
				return;
		end
		err_total++;
		finish_test();
	endtask
	task automatic access(logic w, logic [12:0] a, logic [7:0] d,
		logic [7:0] e);
		int n;
		@(posedge clk);
		valid <= 1'b1;
		req <= '{write: w, addr: a, wdata: d};
		wait_hi(ready, n);
		@(posedge clk);
		valid <= 1'b0;
		if (!w) begin
			wait_hi(rd_valid, n);
			chk("rd_data", e, rd_data);
		end
		wait_hi(ready, n);
		chk("cs_oe_idle", 8'h07, {4'h0, busy, cs_n, oe_n, we_n});
	endtask
	task automatic reset_mid;
		int n;
		@(posedge clk);
		valid <= 1'b1;
		req <= '{write: 1'b0, addr: 13'h0000, wdata: 8'h00};
		wait_hi(ready, n);
		@(posedge clk);
		valid <= 1'b0;
		repeat (3) @(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk("reset_pins", 8'h07, {4'h0, busy, cs_n, oe_n, we_n});
		chk("reset_ready", 8'h01, {6'h00, rd_valid, ready});
	endtask
	task automatic store_hw;
		int n;
		@(posedge clk);
		st_req <= 1'b1;
		wait_hi(st_ready, n);
		@(posedge clk);
		st_req <= 1'b0;
		wait_hi(done, n);
		chk("store_wait", 8'h01, {7'h00, n >= 18});
	endtask
	task automatic power_loss;
		int n;
		@(posedge clk);
		pf <= 1'b1;
		@(posedge clk);
		pf <= 1'b0;
		@(negedge clk);
		chk("ready_in_store", 8'h00, {7'h00, ready});
		chk("busy_in_store", 8'h01, {7'h00, busy});
		wait_hi(ready, n);
		chk("store_len", 8'h01, {7'h00, n >= 17});
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		access(1'b1, 13'h0000, 8'ha5, 8'h00);
		access(1'b1, 13'h1fff, 8'h3c, 8'h00);
		access(1'b0, 13'h0000, 8'h00, 8'ha5);
		access(1'b0, 13'h1fff, 8'h00, 8'h3c);
		access(1'b0, 13'h0aaa, 8'h00, 8'h5a);
		store_hw();
		power_loss();
		reset_mid();
		access(1'b0, 13'h1fff, 8'h00, 8'h3c);
		finish_test();
	end
endmodule
